/* hdl/sdfs_status.sv */
// Status registers of a memory-card host data path: data transfer status and FIFO status.
// Assumes a same-clock data engine that reports events as one-cycle pulses, and card
// pins (card clock, data line 0, data line 1) arriving from outside this clock domain.
// Operation
// - Busy-check mode: flag no busy within 16 card cycles after command; write 1 clears.
// - Read-wait flag drives the read-wait request; writing 1 stops it and clears.
// - Set card-interrupt flag when an I/O card signals interrupt; write 1 clears.
// - Set write CRC status error when card reports failed CRC; write 1 clears.
// - Set receive CRC error when a received block fails CRC; write 1 clears.
// - Set data timeout flag when data or busy wait times out; write 1 clears.
// - Set transfer-finished flag when data counter reaches zero; write 1 clears.
// - Set busy-check-finished flag when busy-check operation completes; write 1 clears.
// - Read-only transmit and receive in-progress indicators.
// - Writing 1 to FIFO clear empties the FIFO; bit returns to 0 itself.
// - Two-bit FIFO error: 01 general fail, 10 last-transfer fail; ones clear.
// - Transmit mode: space-available flag when FIFO not full; DMA request if enabled.
// - Receive mode: data-available flag when FIFO holds 1..64; DMA request if enabled.
// - Transmit-half flag high at 32 bytes or fewer, low at 33 or more.
// - Transmit-empty flag high exactly when FIFO holds zero bytes.
// - Set receive-last flag when FIFO holds final data of all blocks; 1 clears.
// - Receive-full flag high exactly when FIFO holds 64 bytes.
// - Receive-half flag high at 32 bytes or more, low at 31 or fewer.
// - Seven-bit read-only count of bytes held in the FIFO.
//
// The plain strobed port is this design's own decision.
`include "sdfs_params.svh"
`timescale 1ns/100ps
`default_nettype none

module sdfs_status (
  input wire logic coreClk, // Core clock, 20 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [31:0] regAddr, // Register byte address.
  input wire logic [31:0] regWrData, // Register write data.
  input wire logic regWr, // Write strobe.
  input wire logic regRd, // Read strobe.
  output logic [31:0] regRdData, // Read data, valid the cycle after the strobe.
  input wire sdfs_pkg::sdfs_dir_t transferDirection, // Direction setting.
  input wire logic dmaEnable, // DMA enable from the control setting.
  input wire logic cmdSent, // Pulse: command packet has been sent.
  input wire logic readWaitEv, // Pulse: read wait begins.
  input wire logic wrCrcFailEv, // Pulse: card CRC status reported failure.
  input wire logic rxCrcFailEv, // Pulse: received block CRC failed.
  input wire logic timeoutEv, // Pulse: data or busy wait timed out.
  input wire logic counterZeroEv, // Pulse: data counter reached zero.
  input wire logic rxLastEv, // Pulse: final data of all blocks is in the FIFO.
  input wire logic txActive, // Level: transmission in progress.
  input wire logic rxActive, // Level: reception in progress.
  input wire logic fifoPush, // Pulse: one byte written into the FIFO.
  input wire logic fifoPop, // Pulse: one byte taken from the FIFO.
  input wire logic cardClk, // Card clock pin.
  input wire logic cardDat0, // Data line 0 pin, low while the card is busy.
  input wire logic cardDat1, // Data line 1 pin, low for a card interrupt.
  output logic readWaitReq, // Read wait request towards the card.
  output logic dmaReq, // DMA request level.
  output logic fifoFlush // Pulse: FIFO storage is being emptied.
);
  import sdfs_pkg::*;

  // Two-stage synchronisers for the card pins; only stage two feeds logic.
  logic [2:0] pinMeta_q;
  logic [2:0] pinSync_q;
  logic clkPrev_q;
  logic dat1Prev_q;
  always_ff @(posedge coreClk) begin
    pinMeta_q <= {cardDat1, cardDat0, cardClk};
    pinSync_q <= pinMeta_q;
    clkPrev_q <= rst_n ? pinSync_q[0] : 1'b0;
    dat1Prev_q <= rst_n ? pinSync_q[2] : 1'b1;
  end

  // Card clock edges are found by sampling, so the card clock must stay well below 10 MHz.
  wire cardRise = pinSync_q[0] & ~clkPrev_q;
  wire dat0Busy = ~pinSync_q[1];
  wire dat1Fall = ~pinSync_q[2] & dat1Prev_q;

  // Sticky flag update: a hardware set wins over a software clear.
  function automatic logic sticky(input logic q, input logic set, input logic clr);
    sticky = set | (q & ~clr);
  endfunction

  // Register decode.
  wire selDat = regAddr == `SDFS_ADDR_DATSTAT;
  wire selFifo = regAddr == `SDFS_ADDR_FIFOSTAT;
  wire wrDat = regWr & selDat;
  wire wrFifo = regWr & selFifo;
  wire clrBsyAbs = wrDat & regWrData[`SDFS_B_BSYABS];
  wire clrRdWait = wrDat & regWrData[`SDFS_B_RDWAIT];
  wire clrCardIrq = wrDat & regWrData[`SDFS_B_CARDIRQ];
  wire clrWrCrc = wrDat & regWrData[`SDFS_B_WRCRC];
  wire clrRxCrc = wrDat & regWrData[`SDFS_B_RXCRC];
  wire clrTout = wrDat & regWrData[`SDFS_B_TOUT];
  wire clrDone = wrDat & regWrData[`SDFS_B_DONE];
  wire clrBsyFin = wrDat & regWrData[`SDFS_B_BSYFIN];
  wire clrRxLast = wrFifo & regWrData[`SDFS_B_RXLAST];
  wire [1:0] clrErr = {2{wrFifo}} & regWrData[`SDFS_B_ERRHI:`SDFS_B_ERRLO];
  wire fifoClrWr = wrFifo & regWrData[`SDFS_B_FCLR];

  // Busy-check watcher: counts card clock rises after the command.
  sdfs_bstate_t bState_q;
  sdfs_bstate_t bState_d;
  logic [4:0] edgeCnt_q;
  logic [4:0] edgeCnt_d;
  logic bsyAbsSet;
  logic bsyFinSet;
  wire busyMode = transferDirection == SDFS_DIR_BUSY;
  always_comb begin
    bState_d = bState_q;
    edgeCnt_d = edgeCnt_q;
    bsyAbsSet = 1'b0;
    bsyFinSet = 1'b0;
    unique case (bState_q)
      SDFS_BS_IDLE: begin
        edgeCnt_d = 5'h00;
        if (busyMode && cmdSent) begin
          bState_d = SDFS_BS_WAIT;
        end
      end
      SDFS_BS_WAIT: begin
        if (dat0Busy) begin
          bState_d = SDFS_BS_BUSY;
        end else if (cardRise) begin
          edgeCnt_d = edgeCnt_q + 5'h01;
          if (edgeCnt_d == `SDFS_BUSY_WINDOW) begin
            bsyAbsSet = 1'b1;
            bState_d = SDFS_BS_IDLE;
          end
        end
      end
      SDFS_BS_BUSY: begin
        if (!dat0Busy) begin
          bsyFinSet = 1'b1;
          bState_d = SDFS_BS_IDLE;
        end
      end
      default: begin
        bState_d = SDFS_BS_IDLE;
      end
    endcase
  end

  // Watcher state; leaving busy mode abandons the wait.
  always_ff @(posedge coreClk) begin
    if (!rst_n || !busyMode) begin
      bState_q <= SDFS_BS_IDLE;
      edgeCnt_q <= 5'h00;
    end else begin
      bState_q <= bState_d;
      edgeCnt_q <= edgeCnt_d;
    end
  end

  // Data transfer status flags.
  logic bsyAbsent_q;
  logic rdWait_q;
  logic cardIrq_q;
  logic wrCrc_q;
  logic rxCrc_q;
  logic tout_q;
  logic done_q;
  logic bsyFin_q;
  always_ff @(posedge coreClk) begin
    if (!rst_n) begin
      bsyAbsent_q <= 1'b0;
      rdWait_q <= 1'b0;
      cardIrq_q <= 1'b0;
      wrCrc_q <= 1'b0;
      rxCrc_q <= 1'b0;
      tout_q <= 1'b0;
      done_q <= 1'b0;
      bsyFin_q <= 1'b0;
    end else begin
      bsyAbsent_q <= sticky(bsyAbsent_q, bsyAbsSet, clrBsyAbs);
      rdWait_q <= sticky(rdWait_q, readWaitEv, clrRdWait);
      cardIrq_q <= sticky(cardIrq_q, dat1Fall, clrCardIrq);
      wrCrc_q <= sticky(wrCrc_q, wrCrcFailEv, clrWrCrc);
      rxCrc_q <= sticky(rxCrc_q, rxCrcFailEv, clrRxCrc);
      tout_q <= sticky(tout_q, timeoutEv, clrTout);
      done_q <= sticky(done_q, counterZeroEv, clrDone);
      bsyFin_q <= sticky(bsyFin_q, bsyFinSet, clrBsyFin);
    end
  end

  // The request follows the flag, so clearing the flag ends it in the same cycle.
  assign readWaitReq = rdWait_q;

  // FIFO level tracking. A flush beats any push or pop in the same cycle.
  logic [6:0] fifoCnt_q;
  logic [6:0] fifoCnt_d;
  logic [1:0] ffErr_q;
  logic rxLast_q;
  logic flush_q;
  wire isFull = fifoCnt_q == `SDFS_FIFO_DEPTH;
  wire isEmpty = fifoCnt_q == 7'h00;
  wire overrun = fifoPush & ~fifoPop & isFull;
  wire underrun = fifoPop & ~fifoPush & isEmpty;
  wire fifoFault = overrun | underrun;
  // A failure after the last data only needs a FIFO reset, so it gets its own code.
  wire [1:0] errCode = rxLast_q ? `SDFS_ERR_LAST : `SDFS_ERR_GENERAL;
  wire [1:0] errSet = fifoFault ? errCode : 2'h0;
  always_comb begin
    fifoCnt_d = fifoCnt_q;
    if (fifoClrWr) begin
      fifoCnt_d = 7'h00;
    end else if (fifoPush && !fifoPop && !isFull) begin
      fifoCnt_d = fifoCnt_q + 7'h01;
    end else if (fifoPop && !fifoPush && !isEmpty) begin
      fifoCnt_d = fifoCnt_q - 7'h01;
    end
  end

  // FIFO status storage; the clear bit lives one cycle only.
  always_ff @(posedge coreClk) begin
    if (!rst_n) begin
      fifoCnt_q <= 7'h00;
      ffErr_q <= 2'h0;
      rxLast_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      fifoCnt_q <= fifoCnt_d;
      ffErr_q <= errSet | (ffErr_q & ~clrErr);
      rxLast_q <= sticky(rxLast_q, rxLastEv, clrRxLast);
      flush_q <= fifoClrWr;
    end
  end
  assign fifoFlush = flush_q;

  // Level-derived FIFO flags, recomputed from the count every cycle.
  wire txMode = transferDirection == SDFS_DIR_TX;
  wire rxMode = transferDirection == SDFS_DIR_RX;
  wire txAvail = txMode & ~isFull;
  wire rxAvail = rxMode & ~isEmpty;
  // Each direction's level flags read zero in the other modes; in transmit mode reset leaves the half and empty flags set.
  wire txHalf = txMode & (fifoCnt_q <= `SDFS_HALF_LEVEL);
  wire txEmpty = txMode & isEmpty;
  wire rxFull = rxMode & isFull;
  wire rxHalf = rxMode & (fifoCnt_q >= `SDFS_HALF_LEVEL);
  assign dmaReq = dmaEnable & (txAvail | rxAvail);

  // Read views of both registers.
  logic [31:0] datView;
  logic [31:0] fifoView;
  always_comb begin
    datView = `SDFS_RESET_VAL;
    datView[`SDFS_B_BSYABS] = bsyAbsent_q;
    datView[`SDFS_B_RDWAIT] = rdWait_q;
    datView[`SDFS_B_CARDIRQ] = cardIrq_q;
    datView[`SDFS_B_WRCRC] = wrCrc_q;
    datView[`SDFS_B_RXCRC] = rxCrc_q;
    datView[`SDFS_B_TOUT] = tout_q;
    datView[`SDFS_B_DONE] = done_q;
    datView[`SDFS_B_BSYFIN] = bsyFin_q;
    datView[`SDFS_B_TXON] = txActive;
    datView[`SDFS_B_RXON] = rxActive;
    fifoView = `SDFS_RESET_VAL;
    fifoView[`SDFS_B_FCLR] = flush_q;
    fifoView[`SDFS_B_ERRHI:`SDFS_B_ERRLO] = ffErr_q;
    fifoView[`SDFS_B_TXAV] = txAvail;
    fifoView[`SDFS_B_RXAV] = rxAvail;
    fifoView[`SDFS_B_TXHALF] = txHalf;
    fifoView[`SDFS_B_TXEMPTY] = txEmpty;
    fifoView[`SDFS_B_RXLAST] = rxLast_q;
    fifoView[`SDFS_B_RXFULL] = rxFull;
    fifoView[`SDFS_B_RXHALF] = rxHalf;
    fifoView[6:0] = fifoCnt_q;
  end

  // Read data is captured one cycle after the strobe; unmapped addresses return zero.
  wire [31:0] rdSel = selDat ? datView : (selFifo ? fifoView : `SDFS_RESET_VAL);
  always_ff @(posedge coreClk) begin
    if (!rst_n || !regRd) begin
      regRdData <= `SDFS_RESET_VAL;
    end else begin
      regRdData <= rdSel;
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge coreClk); endclocking
  default disable iff (!rst_n);

  a_absent_window: assert property (
    bState_q == SDFS_BS_WAIT && bsyAbsSet |-> edgeCnt_q == 5'h0F && !dat0Busy)
    else $error("Busy-absent flag raised outside the sixteenth card edge.");
  a_readwait_follow: assert property (
    $rose(rdWait_q) |-> readWaitReq ##0 $past(readWaitEv))
    else $error("Read wait flag rose without an event.");
  a_rdwait_clear: assert property (
    rdWait_q && clrRdWait && !readWaitEv |=> !readWaitReq)
    else $error("Read wait request outlived its clearing write.");
  a_set_beats_clear: assert property (
    timeoutEv && clrTout |=> tout_q)
    else $error("Timeout flag lost to a same-cycle clear.");
  a_zero_write_keeps: assert property (
    done_q && !clrDone |=> done_q)
    else $error("Finished flag dropped without a clearing write.");
  a_card_irq_set: assert property (
    dat1Fall |=> cardIrq_q)
    else $error("Card interrupt not recorded.");
  a_crc_flags_set: assert property (
    wrCrcFailEv |=> wrCrc_q)
    else $error("Write CRC status error not recorded.");
  a_rx_crc_set: assert property (
    rxCrcFailEv |=> rxCrc_q)
    else $error("Receive CRC error not recorded.");
  a_finish_set: assert property (
    counterZeroEv |=> done_q)
    else $error("Transfer finished flag not set.");
  a_busy_check_finished_flag_set: assert property (
    bState_q == SDFS_BS_BUSY && busyMode && !dat0Busy |=> bsyFin_q)
    else $error("Busy finish not flagged after busy release.");
  a_flush_empties: assert property (
    fifoClrWr |=> fifoCnt_q == 7'h00 && flush_q ##1 flush_q == $past(fifoClrWr))
    else $error("FIFO clear did not empty or self-clear.");
  a_overrun_error: assert property (
    overrun && !rxLast_q |=> ffErr_q[0])
    else $error("Overrun did not raise the general failure code.");
  a_dma_tx_req: assert property (
    txMode && dmaEnable && fifoCnt_q < `SDFS_FIFO_DEPTH |-> dmaReq)
    else $error("Transmit DMA request missing while FIFO has space.");
  a_rx_avail: assert property (
    rxAvail |-> fifoCnt_q >= 7'h01 && fifoCnt_q <= `SDFS_FIFO_DEPTH)
    else $error("Receive data flag outside its level range.");
  a_half_levels: assert property (
    txHalf == (txMode && fifoCnt_q < 7'h21))
    else $error("Transmit half flag wrong for the count.");
  a_rx_half_full: assert property (
    rxHalf == (rxMode && fifoCnt_q > 7'h1F) && rxFull == (rxMode && fifoCnt_q == 7'h40))
    else $error("Receive half or full flag wrong for the count.");
  a_count_step: assert property (
    fifoPush && !fifoPop && !fifoClrWr && !isFull |=> fifoCnt_q == $past(fifoCnt_q) + 7'h01)
    else $error("FIFO count did not step up on a push.");
  a_read_latency: assert property (
    regRd && selDat |=> regRdData[1:0] == $past({txActive, rxActive}))
    else $error("Progress bits misread.");
  a_timeout_set: assert property (
    timeoutEv |=> tout_q)
    else $error("Data timeout flag not set.");
  a_tx_empty_flag: assert property (
    txMode && fifoCnt_q == 7'h00 |-> txEmpty && txHalf && txAvail)
    else $error("Transmit empty flags wrong for an empty FIFO.");
  a_tx_full_block: assert property (
    txMode && fifoCnt_q == 7'h40 |-> !txAvail && !dmaReq)
    else $error("Transmit space shown while the FIFO is full.");
  a_rx_dma_req: assert property (
    rxMode && dmaEnable && fifoCnt_q != 7'h00 |-> dmaReq)
    else $error("Receive DMA request missing while FIFO holds data.");
  a_last_fail_code: assert property (
    fifoFault && rxLast_q |=> ffErr_q[1])
    else $error("Failure after last data did not raise its own code.");
  a_err_zero_keeps: assert property (
    ffErr_q[0] && !clrErr[0] |=> ffErr_q[0])
    else $error("FIFO error dropped without a clearing write.");
  a_rx_last_set: assert property (
    rxLastEv |=> rxLast_q)
    else $error("Receive last data flag not set.");
  a_count_hold: assert property (
    fifoPush == fifoPop && !fifoClrWr |=> $stable(fifoCnt_q))
    else $error("FIFO count moved without a lone push or pop.");
  a_count_down: assert property (
    fifoPop && !fifoPush && !fifoClrWr && !isEmpty |=> fifoCnt_q == $past(fifoCnt_q) - 7'h01)
    else $error("FIFO count did not step down on a pop.");
  a_absent_count: assert property (
    bState_q == SDFS_BS_WAIT |-> edgeCnt_q < 5'h10)
    else $error("Busy watch counted past its window.");
  a_idle_flags: assert property (
    !txMode && !rxMode |-> !txHalf && !txEmpty && !rxFull && !rxHalf)
    else $error("Level flags shown outside their transfer mode.");
  // Reset itself must be watched, so this check overrides the default disable.
  a_reset_clears: assert property (disable iff (1'b0)
    !rst_n |=> fifoCnt_q == 7'h00 && ffErr_q == 2'h0 && !rdWait_q && !done_q)
    else $error("Status not cleared by reset.");

  c_busy_absent: cover property (bsyAbsSet);
  c_busy_done: cover property (bsyFinSet);
  c_fifo_full: cover property (isFull ##1 fifoClrWr);
  c_last_fail: cover property (rxLast_q && fifoFault);
  c_flush_read: cover property (flush_q && regRd);
endmodule

`default_nettype wire

/* include/sdfs_params.svh */
// Offsets, field positions, reset values and counts of the card data status block.
// Included by the status module and by the bench; holds definitions only.
`ifndef SDFS_PARAMS_SVH
`define SDFS_PARAMS_SVH
`define SDFS_ADDR_DATSTAT 32'h5A000034
`define SDFS_ADDR_FIFOSTAT 32'h5A000038
`define SDFS_RESET_VAL 32'h00000000
`define SDFS_B_BSYABS 11
`define SDFS_B_RDWAIT 10
`define SDFS_B_CARDIRQ 9
`define SDFS_B_WRCRC 7
`define SDFS_B_RXCRC 6
`define SDFS_B_TOUT 5
`define SDFS_B_DONE 4
`define SDFS_B_BSYFIN 3
`define SDFS_B_TXON 1
`define SDFS_B_RXON 0
`define SDFS_B_FCLR 16
`define SDFS_B_ERRHI 15
`define SDFS_B_ERRLO 14
`define SDFS_B_TXAV 13
`define SDFS_B_RXAV 12
`define SDFS_B_TXHALF 11
`define SDFS_B_TXEMPTY 10
`define SDFS_B_RXLAST 9
`define SDFS_B_RXFULL 8
`define SDFS_B_RXHALF 7
`define SDFS_FIFO_DEPTH 7'h40
`define SDFS_HALF_LEVEL 7'h20
`define SDFS_BUSY_WINDOW 5'h10
`define SDFS_ERR_GENERAL 2'h1
`define SDFS_ERR_LAST 2'h2
`endif

/* include/sdfs_pkg.sv */
// Types shared by the card data status block.
// Assumes sdfs_params.svh sits on the include path.
package sdfs_pkg;
  // Transfer direction chosen by software in the data control setting.
  typedef enum logic [1:0] {
    SDFS_DIR_NONE = 2'h0,
    SDFS_DIR_BUSY = 2'h1,
    SDFS_DIR_RX = 2'h2,
    SDFS_DIR_TX = 2'h3
  } sdfs_dir_t;
  // One-hot states of the busy-check watcher.
  typedef enum logic [2:0] {
    SDFS_BS_IDLE = 3'b001,
    SDFS_BS_WAIT = 3'b010,
    SDFS_BS_BUSY = 3'b100
  } sdfs_bstate_t;
endpackage

/* verif/sdfs_card_model.sv */
// Behavioural memory card: card clock, busy on data line 0, interrupt on data line 1.
// Assumes the bench raises frame for the length of each card operation.
`timescale 1ns/100ps
`default_nettype none

module sdfs_card_model (
  output logic cardClk, // Card clock, runs only within frames.
  output logic cardDat0, // Data line 0, pulled up when released.
  output logic cardDat1, // Data line 1, pulled up when released.
  input wire logic frame, // High while a card operation runs.
  input wire logic busyOn, // Card shows busy in this frame.
  input wire logic irq // Rising edge: card signals an interrupt.
);
  // The clock stands still between frames, so no edge can leak into an idle check.
  initial begin
    cardClk = 1'b0;
    forever begin
      wait (frame === 1'b1);
      #200 cardClk = 1'b1;
      #200 cardClk = 1'b0;
    end
  end
  // Busy begins after three card clocks and lasts four, well inside the watch window.
  initial begin
    cardDat0 = 1'b1;
    forever begin
      @(posedge frame);
      if (busyOn) begin
        repeat (3) @(negedge cardClk);
        cardDat0 = 1'b0;
        repeat (4) @(negedge cardClk);
        cardDat0 = 1'b1;
      end
    end
  end
  // An interrupt is a short low pulse; the pull-up then restores the line.
  initial begin
    cardDat1 = 1'b1;
    forever begin
      @(posedge irq);
      cardDat1 = 1'b0;
      #800 cardDat1 = 1'b1;
    end
  end
endmodule

`default_nettype wire

/* verif/sdfs_status_tb_top.sv */
// Self-checking bench of the card data status block, with a card model on the pins.
// Assumes sdfs_params.svh on the include path and the package compiled first.
`include "sdfs_params.svh"
`timescale 1ns/100ps
`default_nettype none

module sdfs_status_tb_top;
  import sdfs_pkg::*;
  logic coreClk = 0, rst_n = 0, regWr = 0, regRd = 0, dmaEnable = 0, cmdSent = 0;
  logic [31:0] regAddr = 0, regWrData = 0, rdData;
  logic [4:0] ev = 0;
  logic rxLastEv = 0, txActive = 0, rxActive = 0, fifoPush = 0, fifoPop = 0;
  logic frame = 0, busyOn = 0, irq = 0;
  sdfs_dir_t dir = SDFS_DIR_NONE;
  wire logic [31:0] regRdData;
  wire logic cardClk, cardDat0, cardDat1, readWaitReq, dmaReq, fifoFlush;
  int failCount = 0, samplesChecked = 0, cycles = 0;
  int evBit[5] = '{10, 7, 6, 5, 4};
  localparam logic [31:0] DAT = `SDFS_ADDR_DATSTAT;
  localparam logic [31:0] FST = `SDFS_ADDR_FIFOSTAT;
  localparam logic [31:0] RXM = 32'hFFFFF1FF;
  localparam logic [31:0] TXM = 32'hFFFFFC7F;

  sdfs_status dut_u (.coreClk(coreClk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .transferDirection(dir), .dmaEnable(dmaEnable), .cmdSent(cmdSent),
    .readWaitEv(ev[0]), .wrCrcFailEv(ev[1]), .rxCrcFailEv(ev[2]), .timeoutEv(ev[3]),
    .counterZeroEv(ev[4]), .rxLastEv(rxLastEv), .txActive(txActive), .rxActive(rxActive),
    .fifoPush(fifoPush), .fifoPop(fifoPop), .cardClk(cardClk), .cardDat0(cardDat0),
    .cardDat1(cardDat1), .readWaitReq(readWaitReq), .dmaReq(dmaReq), .fifoFlush(fifoFlush));
  sdfs_card_model card_u (.cardClk(cardClk), .cardDat0(cardDat0), .cardDat1(cardDat1),
    .frame(frame), .busyOn(busyOn), .irq(irq));

  // Clock of 50 ns and a hang guard well above the fewer than one thousand cycles the run needs.
  initial forever #25 coreClk = ~coreClk;
  always @(posedge coreClk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      endOfTest();
    end
  end

  task automatic endOfTest();
    if (failCount == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got, logic [31:0] m);
    samplesChecked++;
    if ((got & m) !== (exp & m)) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp & m, got & m);
    end
  endtask

  // One-cycle strobes; the read data stands only in the cycle after the strobe.
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge coreClk);
    regWr <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge coreClk);
    regWr <= 0;
  endtask

  task automatic rd(logic [31:0] a, logic [31:0] exp, logic [31:0] m);
    @(posedge coreClk);
    regRd <= 1;
    regAddr <= a;
    @(posedge coreClk);
    regRd <= 0;
    #1 rdData = regRdData;
    chk("register", exp, rdData, m);
  endtask

  task automatic fifoStep(bit push);
    @(posedge coreClk);
    if (push) fifoPush <= 1;
    else fifoPop <= 1;
    @(posedge coreClk);
    fifoPush <= 0;
    fifoPop <= 0;
  endtask

  // Expected FIFO view from the byte count, the mode and the error code.
  function automatic logic [31:0] fv(int c, bit tx, logic [1:0] e);
    logic [6:0] c7;
    c7 = c[6:0];
    fv = {16'h0000, e, tx && c < 64, !tx && c > 0, c <= 32, c == 0, 1'b0, c == 64, c >= 32, c7};
  endfunction

  task automatic busyRun(bit b, logic [31:0] exp);
    busyOn <= b;
    @(posedge coreClk);
    cmdSent <= 1;
    @(posedge coreClk);
    cmdSent <= 0;
    frame <= 1;
    repeat (220) @(posedge coreClk);
    frame <= 0;
    rd(DAT, exp, 32'h00000808);
    wr(DAT, 32'h00000808);
  endtask

  initial begin
    repeat (16) @(posedge coreClk);
    rst_n <= 1;
    rd(DAT, 32'h0, 32'hFFFFFFFF);
    rd(FST, 32'h0, 32'hFFFFFFFF);
    rd(32'h5A00003C, 32'h0, 32'hFFFFFFFF);
    // Sticky event flags: set, survive a zero write, then clear on a one.
    for (int i = 0; i < 5; i++) begin
      @(posedge coreClk);
      ev[i] <= 1;
      @(posedge coreClk);
      ev <= 0;
      rd(DAT, 32'h1 << evBit[i], 32'h1 << evBit[i]);
      if (i == 0) chk("readWaitReq", 1, readWaitReq, 1);
      wr(DAT, 32'h0);
      rd(DAT, 32'h1 << evBit[i], 32'h1 << evBit[i]);
      wr(DAT, 32'h1 << evBit[i]);
      rd(DAT, 32'h0, 32'h1 << evBit[i]);
      if (i == 0) chk("readWaitReq", 0, readWaitReq, 1);
    end
    // A hardware set in the clearing cycle wins.
    @(posedge coreClk);
    ev[3] <= 1;
    regWr <= 1;
    regAddr <= DAT;
    regWrData <= 32'h00000020;
    @(posedge coreClk);
    ev <= 0;
    regWr <= 0;
    rd(DAT, 32'h20, 32'h20);
    wr(DAT, 32'h20);
    txActive <= 1;
    rd(DAT, 32'h2, 32'h3);
    txActive <= 0;
    rxActive <= 1;
    rd(DAT, 32'h1, 32'h3);
    rxActive <= 0;
    // Receive mode with DMA: fill to full, then one push too many.
    dir <= SDFS_DIR_RX;
    dmaEnable <= 1;
    rd(FST, fv(0, 0, 0), RXM);
    for (int c = 1; c <= 64; c++) begin
      fifoStep(1);
      if (c < 3 || c == 31 || c == 32 || c > 62) begin
        rd(FST, fv(c, 0, 0), RXM);
        chk("dmaReq", 1, dmaReq, 1);
      end
    end
    fifoStep(1);
    rd(FST, fv(64, 0, `SDFS_ERR_GENERAL), RXM);
    wr(FST, 32'h00004000);
    rd(FST, fv(64, 0, 0), RXM);
    // Transmit mode: drain to empty, then underrun after the last data arrived.
    dir <= SDFS_DIR_TX;
    for (int c = 64; c >= 0; c--) begin
      if (c > 62 || c == 33 || c == 32 || c < 2) begin
        rd(FST, fv(c, 1, 0), TXM);
        chk("dmaReq", c < 64, dmaReq, 1);
      end
      if (c > 0) fifoStep(0);
    end
    dmaEnable <= 0;
    rd(FST, fv(0, 1, 0), TXM);
    chk("dmaReq", 0, dmaReq, 1);
    @(posedge coreClk);
    rxLastEv <= 1;
    @(posedge coreClk);
    rxLastEv <= 0;
    rd(FST, 32'h200, 32'h200);
    fifoStep(0);
    rd(FST, {16'h0, `SDFS_ERR_LAST, 14'h0200}, 32'h0000C27F);
    // Software clears the error and flushes the FIFO after an oversize last read.
    wr(FST, 32'h0000C200);
    rd(FST, 32'h0, 32'h0000C200);
    fifoStep(1);
    fifoStep(1);
    rd(FST, 32'h2, 32'h7F);
    wr(FST, 32'h00010000);
    #1 chk("fifoFlush", 1, fifoFlush, 1);
    rd(FST, 32'h0, 32'h0001007F);
    chk("fifoFlush", 0, fifoFlush, 1);
    // A read right behind the clear write catches the clear bit in its only cycle.
    fifoStep(1);
    @(posedge coreClk);
    regWr <= 1;
    regAddr <= FST;
    regWrData <= 32'h00010000;
    @(posedge coreClk);
    regWr <= 0;
    regRd <= 1;
    @(posedge coreClk);
    regRd <= 0;
    #1 rdData = regRdData;
    chk("fifoClear", 32'h00010000, rdData, 32'h0001007F);
    // Busy check: with busy the finish flag, without busy the absent flag.
    dir <= SDFS_DIR_BUSY;
    busyRun(1, 32'h00000008);
    busyRun(0, 32'h00000800);
    irq <= 1;
    repeat (40) @(posedge coreClk);
    irq <= 0;
    rd(DAT, 32'h200, 32'h200);
    wr(DAT, 32'h200);
    rd(DAT, 32'h0, 32'h200);
    // Reset in mid-run, with a flag and a FIFO level set, returns both registers to zero.
    @(posedge coreClk);
    ev[4] <= 1;
    fifoPush <= 1;
    @(posedge coreClk);
    ev <= 0;
    fifoPush <= 0;
    rst_n <= 0;
    repeat (3) @(posedge coreClk);
    rst_n <= 1;
    rd(DAT, 32'h0, 32'hFFFFFFFF);
    rd(FST, 32'h0, 32'hFFFFFFFF);
    endOfTest();
  end
endmodule

`default_nettype wire
